/* File: usb_pkg.sv */
// Package for the sync-busy and receive-error-count block.
// Assumes a single 100 MHz clock domain; registers sit at fixed byte offsets.
package usb_pkg;
  // Register offsets
  localparam logic [7:0]  OFF_CTRL_FIRST       = 8'h00;
  localparam logic [7:0]  OFF_CTRL_SECOND      = 8'h04;
  localparam logic [7:0]  OFF_SYNC_BUSY        = 8'h1c;
  localparam logic [7:0]  OFF_ERR_COUNT        = 8'h20;
  // First control register fields
  localparam int          CF_SOFT_RESET_BIT    = 0;
  localparam int          CF_ENABLE_BIT        = 1;
  localparam int          CF_FRAME_FMT_LSB     = 24;
  localparam int          FRAME_FMT_BITS       = 4;
  localparam logic [3:0]  FRAME_FMT_SMART_CARD = 4'h7;
  // Sync busy fields
  localparam int          SB_SOFT_RESET_BIT    = 0;
  localparam int          SB_ENABLE_BIT        = 1;
  localparam int          SB_CTRL_SECOND_BIT   = 2;
  localparam int          SB_ERR_COUNT_BIT     = 3;
  // Reset values
  localparam logic [31:0] CTRL_FIRST_RESET     = 32'h0000_0000;
  localparam logic [31:0] CTRL_SECOND_RESET    = 32'h0000_0000;
  localparam logic [7:0]  ERR_COUNT_RESET      = 8'h00;
  // Error counter ceiling
  localparam logic [7:0]  ERR_COUNT_MAX        = 8'hff;
  // Synchroniser delay in cycles
  localparam int          SYNC_CYCLES          = 3;
endpackage

/* File: usb_sync_timer.sv */
// One busy flag that stays up for a fixed number of cycles after a start pulse.
// Assumes start is a one-cycle pulse in the clock domain.
module usb_sync_timer #(
  parameter int CYCLES = 3
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic start,
  output logic      busy
);
  logic [3:0] cnt_q;

  // Count down while busy; a new start reloads
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 4'h0;
    end else if (start) begin
      cnt_q <= 4'(CYCLES);
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  assign busy = (cnt_q != 4'h0);
endmodule

/* File: usb_sync_busy.sv */
// Sync-busy tracking and smart-card receive error counter.
// Assumes a simple register port (sel/write/addr/wdata) and error pulses from the receiver.
module usb_sync_busy (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        reg_sel,
  input  wire logic        reg_write,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        sleep_wake,
  input  wire logic        parity_err,
  input  wire logic        nack_err,
  output logic [31:0]      reg_rdata,
  output logic             reg_ready,
  output logic             reg_error,
  output logic             periph_enable,
  output logic [31:0]      ctrl_second_out
);
  logic [31:0] ctrl_first_q;
  logic [31:0] ctrl_second_q;
  logic [7:0]  rxerr_q;
  logic [7:0]  rxerr_d;
  logic        wr_first;
  logic        wr_second;
  logic        rd_rxerr;
  logic        srst_start;
  logic        en_start;
  logic        second_start;
  logic        rx_start;
  logic        srst_busy;
  logic        en_busy;
  logic        second_busy;
  logic        rx_busy;
  logic        bad_second;
  logic        err_event;
  logic        smart_card;
  logic [31:0] rdata_d;
  logic        srst_done;
  logic        srst_busy_q;

  // Address decode
  always_comb begin
    wr_first  = 1'b0;
    wr_second = 1'b0;
    rd_rxerr  = 1'b0;
    if (reg_sel && reg_write && reg_addr == usb_pkg::OFF_CTRL_FIRST) begin
      wr_first = 1'b1;
    end else if (reg_sel && reg_write && reg_addr == usb_pkg::OFF_CTRL_SECOND) begin
      wr_second = 1'b1;
    end else if (reg_sel && !reg_write && reg_addr == usb_pkg::OFF_ERR_COUNT) begin
      rd_rxerr = 1'b1;
    end
  end

  // Start pulses; a reset request outranks every other part of the same write
  assign bad_second   = wr_second && second_busy;
  assign srst_start   = wr_first && reg_wdata[usb_pkg::CF_SOFT_RESET_BIT] && !srst_busy;
  assign en_start     = wr_first && !reg_wdata[usb_pkg::CF_SOFT_RESET_BIT] && !srst_busy;
  assign second_start = wr_second && !bad_second && ctrl_first_q[usb_pkg::CF_ENABLE_BIT];
  assign smart_card   = ctrl_first_q[usb_pkg::CF_FRAME_FMT_LSB +: usb_pkg::FRAME_FMT_BITS]
                        == usb_pkg::FRAME_FMT_SMART_CARD;
  assign err_event    = smart_card && (parity_err || nack_err);
  assign rx_start     = err_event || sleep_wake;

  // Busy timers, one per synchronised item
  usb_sync_timer #(.CYCLES(usb_pkg::SYNC_CYCLES)) u_srst_timer (
    .clock(clock), .sys_rst(sys_rst), .start(srst_start), .busy(srst_busy));
  usb_sync_timer #(.CYCLES(usb_pkg::SYNC_CYCLES)) u_en_timer (
    .clock(clock), .sys_rst(sys_rst), .start(en_start), .busy(en_busy));
  usb_sync_timer #(.CYCLES(usb_pkg::SYNC_CYCLES)) u_second_timer (
    .clock(clock), .sys_rst(sys_rst), .start(second_start), .busy(second_busy));
  usb_sync_timer #(.CYCLES(usb_pkg::SYNC_CYCLES)) u_rx_timer (
    .clock(clock), .sys_rst(sys_rst), .start(rx_start), .busy(rx_busy));

  // Software reset completes when its busy timer falls
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      srst_busy_q <= 1'b0;
    end else begin
      srst_busy_q <= srst_busy;
    end
  end
  assign srst_done = srst_busy_q && !srst_busy;

  // First control register; reset request reads back until done
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_first_q <= usb_pkg::CTRL_FIRST_RESET;
    end else if (srst_done) begin
      ctrl_first_q <= usb_pkg::CTRL_FIRST_RESET;
    end else if (srst_start) begin
      ctrl_first_q[usb_pkg::CF_SOFT_RESET_BIT] <= 1'b1;
    end else if (en_start) begin
      ctrl_first_q <= reg_wdata;
    end
  end

  // Second control register; busy writes are dropped
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_second_q <= usb_pkg::CTRL_SECOND_RESET;
    end else if (srst_done) begin
      ctrl_second_q <= usb_pkg::CTRL_SECOND_RESET;
    end else if (wr_second && !bad_second && !srst_busy) begin
      ctrl_second_q <= reg_wdata;
    end
  end

  // Error counter: saturating, cleared on read, an error in the read cycle counts from zero
  always_comb begin
    rxerr_d = rxerr_q;
    if (rd_rxerr) begin
      rxerr_d = usb_pkg::ERR_COUNT_RESET;
    end
    if (err_event && rxerr_d != usb_pkg::ERR_COUNT_MAX) begin
      rxerr_d = rxerr_d + 8'h01;
    end
    if (srst_done) begin
      rxerr_d = usb_pkg::ERR_COUNT_RESET;
    end
  end

  // Error counter register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rxerr_q <= usb_pkg::ERR_COUNT_RESET;
    end else begin
      rxerr_q <= rxerr_d;
    end
  end

  // Read mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_addr == usb_pkg::OFF_CTRL_FIRST) begin
      rdata_d = ctrl_first_q;
    end else if (reg_addr == usb_pkg::OFF_CTRL_SECOND) begin
      rdata_d = ctrl_second_q;
    end else if (reg_addr == usb_pkg::OFF_SYNC_BUSY) begin
      rdata_d[usb_pkg::SB_SOFT_RESET_BIT]  = srst_busy;
      rdata_d[usb_pkg::SB_ENABLE_BIT]      = en_busy;
      rdata_d[usb_pkg::SB_CTRL_SECOND_BIT] = second_busy;
      rdata_d[usb_pkg::SB_ERR_COUNT_BIT]   = rx_busy;
    end else if (reg_addr == usb_pkg::OFF_ERR_COUNT) begin
      rdata_d[7:0] = rxerr_q;
    end
  end

  // Registered bus answer, one cycle after the access
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
      reg_ready <= 1'b0;
      reg_error <= 1'b0;
    end else begin
      reg_rdata <= (reg_sel && !reg_write) ? rdata_d : 32'h0000_0000;
      reg_ready <= reg_sel;
      reg_error <= bad_second;
    end
  end

  // Registered control outputs; the done cycle is masked so no stale enable slips out
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      periph_enable   <= 1'b0;
      ctrl_second_out <= usb_pkg::CTRL_SECOND_RESET;
    end else begin
      periph_enable   <= ctrl_first_q[usb_pkg::CF_ENABLE_BIT] && !srst_busy && !srst_done;
      ctrl_second_out <= ctrl_second_q;
    end
  end

  // Assertions share one clock and the block reset
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // Bus answer and busy flags
  chk_second_err_resp: assert property (wr_second && second_busy |=> reg_error)
    else $error("busy second control write without error");
  chk_no_stray_error: assert property (!(wr_second && second_busy) |=> !reg_error)
    else $error("bus error without a busy write");
  chk_ready_pulse: assert property (reg_sel |=> reg_ready)
    else $error("access not answered");
  chk_second_busy_set: assert property (second_start |=> second_busy [*3])
    else $error("second control busy not held");
  chk_enable_busy_set: assert property (en_start |=> en_busy)
    else $error("enable busy not set");
  chk_rx_busy_err: assert property (err_event |=> rx_busy [*3])
    else $error("rx busy not raised on error");
  chk_wake_busy: assert property (sleep_wake |=> rx_busy)
    else $error("rx busy not raised on wake");

  // Counter and software reset
  chk_count_inc: assert property (err_event && !rd_rxerr && !srst_done
    && rxerr_q != usb_pkg::ERR_COUNT_MAX |=> rxerr_q == $past(rxerr_q) + 8'h01)
    else $error("error count did not increment");
  chk_read_clear: assert property (rd_rxerr && !err_event |=> rxerr_q == 8'h00)
    else $error("count not cleared on read");
  chk_count_sat: assert property (rxerr_q == usb_pkg::ERR_COUNT_MAX && !rd_rxerr && !srst_done
    |=> rxerr_q == usb_pkg::ERR_COUNT_MAX)
    else $error("count wrapped");
  chk_srst_disable: assert property (srst_done |=> !periph_enable)
    else $error("reset left block enabled");
  chk_srst_regs: assert property (srst_done |=> ctrl_first_q == usb_pkg::CTRL_FIRST_RESET)
    else $error("reset left first control set");
  chk_srst_out_off: assert property (srst_busy |=> !periph_enable)
    else $error("block enabled while resetting");
  chk_srst_busy: assert property (srst_start |=> srst_busy [*3] ##1 !srst_busy)
    else $error("reset busy wrong length");

  // Main scenarios
  cov_second_error: cover property (wr_second && second_busy);
  cov_count_err: cover property (err_event ##[1:20] rd_rxerr);
  cov_srst: cover property (srst_start ##[1:10] srst_done);
  cov_count_sat: cover property (rxerr_q == usb_pkg::ERR_COUNT_MAX && rd_rxerr);
endmodule

/* File: usb_card_model.sv */
// Far-side card model: turns bench requests into error pulses.
// Assumes requests change at the falling edge of clock.
module usb_card_model (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic par_req,
  input  wire logic nack_req,
  output logic      parity_err,
  output logic      nack_err
);
  timeunit 1ns;
  timeprecision 1ps;
  // One error pulse per requested cycle, launched at the rising edge
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      parity_err <= 1'b0;
      nack_err   <= 1'b0;
    end else begin
      parity_err <= par_req;
      nack_err   <= nack_req;
    end
  end
endmodule

/* File: tb_top.sv */
// Bench for the sync-busy and receive error count block.
// Assumes the register port contract: ready exactly one cycle after an access.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock           = 1'b0;
  logic        sys_rst         = 1'b1;
  logic        reg_sel         = 1'b0;
  logic        reg_write       = 1'b0;
  logic        sleep_wake      = 1'b0;
  logic        par_req         = 1'b0;
  logic        nack_req        = 1'b0;
  logic [7:0]  reg_addr        = 8'h00;
  logic [31:0] reg_wdata       = 32'h0000_0000;
  logic [31:0] reg_rdata;
  logic [31:0] ctrl_second_out;
  logic [31:0] rd;
  logic        parity_err;
  logic        nack_err;
  logic        reg_ready;
  logic        reg_error;
  logic        periph_enable;
  logic        er;
  int          fail_count      = 0;
  int          samples_checked = 0;

  usb_sync_busy dut_u (.clock(clock), .sys_rst(sys_rst), .reg_sel(reg_sel),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .sleep_wake(sleep_wake), .parity_err(parity_err), .nack_err(nack_err),
    .reg_rdata(reg_rdata), .reg_ready(reg_ready), .reg_error(reg_error),
    .periph_enable(periph_enable), .ctrl_second_out(ctrl_second_out));
  usb_card_model card_u (.clock(clock), .sys_rst(sys_rst), .par_req(par_req),
    .nack_req(nack_req), .parity_err(parity_err), .nack_err(nack_err));

  // Clock at 100 MHz
  initial begin
    forever #5 clock = ~clock;
  end

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One access: taken at the next rising edge, answer read at the falling edge after it
  task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
    reg_sel   = 1'b1;
    reg_write = w;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clock);
    rd = reg_rdata;
    er = reg_error;
    chk("ready", 32'h0000_0001, {31'h0, reg_ready});
    reg_sel = 1'b0;
    @(negedge clock);
  endtask

  // Hold an error request for n cycles, then let it settle
  task automatic errs(logic [1:0] kind, int n);
    {nack_req, par_req} = kind;
    repeat (n) @(negedge clock);
    {nack_req, par_req} = 2'b00;
    repeat (3) @(negedge clock);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #50us;
    fail_count++;
    print_verdict();
  end

  // Values straight after reset
  task automatic t_reset_values();
    acc(1'b0, 8'h1c, 32'h0000_0000);
    chk("busy reset", 32'h0000_0000, rd);
    acc(1'b0, 8'h20, 32'h0000_0000);
    chk("count reset", 32'h0000_0000, rd);
  endtask

  // Enable with plain framing: busy bit 1, errors ignored
  task automatic t_enable();
    acc(1'b1, 8'h00, 32'h0000_0002);
    acc(1'b0, 8'h1c, 32'h0000_0000);
    chk("enable busy", 32'h0000_0001, {31'h0, rd[1]});
    errs(2'b11, 2);
    chk("enabled", 32'h0000_0001, {31'h0, periph_enable});
    acc(1'b0, 8'h20, 32'h0000_0000);
    chk("plain count", 32'h0000_0000, rd);
  endtask

  // Back-to-back second control writes while enabled, then one after the busy time
  task automatic t_second_ctrl();
    acc(1'b1, 8'h04, 32'h0000_0001);
    chk("first err", 32'h0000_0000, {31'h0, er});
    acc(1'b1, 8'h04, 32'h0000_0002);
    chk("busy err", 32'h0000_0001, {31'h0, er});
    chk("second ctrl kept", 32'h0000_0001, ctrl_second_out);
    acc(1'b1, 8'h04, 32'h0000_0003);
    chk("late err", 32'h0000_0000, {31'h0, er});
    acc(1'b0, 8'h1c, 32'h0000_0000);
    chk("second busy", 32'h0000_0001, {31'h0, rd[2]});
    chk("second ctrl new", 32'h0000_0003, ctrl_second_out);
  endtask

  // Smart card framing: parity, nack, both at once, then saturation
  task automatic t_smart_card();
    acc(1'b1, 8'h00, 32'h0700_0002);
    repeat (4) @(negedge clock);
    errs(2'b01, 1);
    errs(2'b10, 1);
    errs(2'b11, 1);
    acc(1'b0, 8'h20, 32'h0000_0000);
    chk("count", 32'h0000_0003, rd);
    acc(1'b0, 8'h20, 32'h0000_0000);
    chk("cleared", 32'h0000_0000, rd);
    errs(2'b01, 260);
    acc(1'b0, 8'h20, 32'h0000_0000);
    chk("saturate", 32'h0000_00ff, rd);
  endtask

  // Wake from sleep raises busy bit 3
  task automatic t_wake();
    acc(1'b0, 8'h1c, 32'h0000_0000);
    chk("idle busy", 32'h0000_0000, {31'h0, rd[3]});
    sleep_wake = 1'b1;
    @(negedge clock);
    sleep_wake = 1'b0;
    acc(1'b0, 8'h1c, 32'h0000_0000);
    chk("wake busy", 32'h0000_0001, {31'h0, rd[3]});
  endtask

  // Software reset after fresh errors
  task automatic t_soft_reset();
    errs(2'b01, 2);
    acc(1'b1, 8'h00, 32'h0000_0001);
    acc(1'b0, 8'h1c, 32'h0000_0000);
    chk("reset busy", 32'h0000_0001, {31'h0, rd[0]});
    repeat (3) @(negedge clock);
    chk("off", 32'h0000_0000, {31'h0, periph_enable});
    chk("second ctrl reset", 32'h0000_0000, ctrl_second_out);
    acc(1'b0, 8'h00, 32'h0000_0000);
    chk("first ctrl reset", 32'h0000_0000, rd);
    acc(1'b0, 8'h20, 32'h0000_0000);
    chk("count cleared", 32'h0000_0000, rd);
    acc(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
  endtask

  initial begin
    repeat (6) @(negedge clock);
    sys_rst = 1'b0;
    t_reset_values();
    t_enable();
    t_second_ctrl();
    t_smart_card();
    t_wake();
    t_soft_reset();
    print_verdict();
  end
endmodule
